//--- logic/cvd_consts.svh
// constants for the condition and vector decode block
`ifndef CVD_CONSTS_SVH
`define CVD_CONSTS_SVH

`define CVD_ADDR_W        24
`define CVD_OFFS_W        6
`define CVD_DM_ADDR_W     32
`define CVD_PX_LOW_W      16
`define CVD_PX_HIGH_W     32
`define CVD_PX_W          48
`define CVD_SHAMT_W       8
`define CVD_FIELD_W       6
`define CVD_SLOT_W        5
`define CVD_VEC_W         8
`define CVD_SLOT_STEP     3

// vector slots; address is slot times eight
`define CVD_SLOT_RESET    5'h01
`define CVD_SLOT_STACK    5'h03
`define CVD_SLOT_TMR_HI   5'h04
`define CVD_SLOT_IRQ3     5'h05
`define CVD_SLOT_CB7      5'h0B
`define CVD_SLOT_CB15     5'h0C
`define CVD_SLOT_TMR_LO   5'h0E
`define CVD_SLOT_FIX_OVF  5'h0F
`define CVD_SLOT_FLT_OVF  5'h10
`define CVD_SLOT_FLT_UNF  5'h11
`define CVD_SLOT_FLT_INV  5'h12

`define CVD_RESET_VECTOR  8'h08

`endif

//--- logic/cvd_pkg.sv
// types shared by the condition and vector decode block
package cvd_pkg;

  // condition and termination codes, pairs of test and negation
  typedef enum logic [4:0] {
    CVD_EQ, CVD_NE, CVD_GE, CVD_LT, CVD_LE, CVD_GT,
    CVD_AC, CVD_NOT_AC, CVD_AV, CVD_NOT_AV, CVD_MV, CVD_NOT_MV,
    CVD_MS, CVD_NOT_MS, CVD_SV, CVD_NOT_SV, CVD_SZ, CVD_NOT_SZ,
    CVD_FLAG0, CVD_NOT_FLAG0, CVD_FLAG1, CVD_NOT_FLAG1,
    CVD_FLAG2, CVD_NOT_FLAG2, CVD_FLAG3, CVD_NOT_FLAG3,
    CVD_TF, CVD_NOT_TF, CVD_LCE, CVD_NOT_LCE, CVD_FOREVER, CVD_TRUE
  } cvd_cond_t;

endpackage

//--- logic/cvd_cond_eval.sv
// combinational evaluator of one condition or termination code
`timescale 1ns/10ps

module cvd_cond_eval
(
  input  cvd_pkg::cvd_cond_t code,
  input  wire logic          alu_zero,
  input  wire logic          alu_neg,
  input  wire logic          alu_carry,
  input  wire logic          alu_ovf,
  input  wire logic          mul_ovf,
  input  wire logic          mul_sign,
  input  wire logic          shf_ovf,
  input  wire logic          shf_zero,
  input  wire logic [3:0]    flag_in,
  input  wire logic          bit_test_flag,
  input  wire logic          loop_count_expired,
  output logic               result
);

  always_comb
  begin
    case (code)
      // RULE_02 sign and zero tests
      cvd_pkg::CVD_EQ:        result = alu_zero;
      cvd_pkg::CVD_NE:        result = !alu_zero;
      cvd_pkg::CVD_GE:        result = !alu_neg;
      cvd_pkg::CVD_LT:        result = alu_neg;
      cvd_pkg::CVD_LE:        result = alu_neg | alu_zero;
      cvd_pkg::CVD_GT:        result = !alu_neg & !alu_zero;
      // RULE_17 status and flag tests
      cvd_pkg::CVD_AC:        result = alu_carry;
      cvd_pkg::CVD_NOT_AC:    result = !alu_carry;
      cvd_pkg::CVD_AV:        result = alu_ovf;
      cvd_pkg::CVD_NOT_AV:    result = !alu_ovf;
      cvd_pkg::CVD_MV:        result = mul_ovf;
      cvd_pkg::CVD_NOT_MV:    result = !mul_ovf;
      cvd_pkg::CVD_MS:        result = mul_sign;
      cvd_pkg::CVD_NOT_MS:    result = !mul_sign;
      cvd_pkg::CVD_SV:        result = shf_ovf;
      cvd_pkg::CVD_NOT_SV:    result = !shf_ovf;
      cvd_pkg::CVD_SZ:        result = shf_zero;
      cvd_pkg::CVD_NOT_SZ:    result = !shf_zero;
      cvd_pkg::CVD_FLAG0:     result = flag_in[0];
      cvd_pkg::CVD_NOT_FLAG0: result = !flag_in[0];
      cvd_pkg::CVD_FLAG1:     result = flag_in[1];
      cvd_pkg::CVD_NOT_FLAG1: result = !flag_in[1];
      cvd_pkg::CVD_FLAG2:     result = flag_in[2];
      cvd_pkg::CVD_NOT_FLAG2: result = !flag_in[2];
      cvd_pkg::CVD_FLAG3:     result = flag_in[3];
      cvd_pkg::CVD_NOT_FLAG3: result = !flag_in[3];
      cvd_pkg::CVD_TF:        result = bit_test_flag;
      cvd_pkg::CVD_NOT_TF:    result = !bit_test_flag;
      // RULE_03 loop count expiry
      cvd_pkg::CVD_LCE:       result = loop_count_expired;
      cvd_pkg::CVD_NOT_LCE:   result = !loop_count_expired;
      // RULE_04 constant codes
      cvd_pkg::CVD_FOREVER:   result = 1'b0;
      cvd_pkg::CVD_TRUE:      result = 1'b1;
      default:                result = 1'b0;
    endcase
  end

endmodule // cvd_cond_eval

//--- logic/cvd_decoder.sv
// condition, branch, operand and vector decode of the dsp core
`timescale 1ns/10ps
`include "cvd_consts.svh"

// Function
// RULE_01: a conditional instruction does nothing at all unless its condition is true; px, address copy, shifter and multifunction writes ignore it.
// RULE_02: eq, ne, ge, lt, le and gt come from the last alu result compared with zero.
// RULE_03: lce ends a counted loop on expiry and not lce is true while the count remains.
// RULE_04: forever is always false and true is always true.
// RULE_05: loop abort pops loop and pc stacks on a taken branch; delayed branch lets fetched work finish.
// RULE_06: jump and call take a 24-bit absolute target or a signed 6-bit offset from the branch pc.
// RULE_07: multifunction multiplier reads r0-3 and r4-7, alu reads r8-11 and r12-15.
// RULE_08: fixed multifunction multiply is signed fractional, rounded to a register, unrounded to mrf.
// RULE_09: field deposit and extract decode 6-bit position and length, other shifts an 8-bit amount.
// RULE_10: the 48-bit bus exchange register joins a 16-bit and a 32-bit half, each addressable.
// RULE_11: last data and program address copies are read-only, as are the pc, fetch and decode addresses.
// RULE_12: status or loop stack overflow or full pc stack vectors to 0x18.
// RULE_13: timer reaching zero vectors to 0x20 on high priority or 0x70 on low priority.
// RULE_14: circular buffer 7 overflow vectors to 0x58 and buffer 15 overflow to 0x60.
// RULE_15: fetching starts at 8 after reset release and reset cannot be masked.
// RULE_16: exceptions vector at 0x78, 0x80, 0x88, 0x90 and irq 3 to 0 sit between timer and reserved.
// RULE_17: flags, bit test, alu carry and overflow, multiplier and shifter status are testable.
module cvd_decoder
#(
  parameter int ADDR_W = `CVD_ADDR_W,
  parameter int OFFS_W = `CVD_OFFS_W
)
(
  input  wire logic                      mclk,
  input  wire logic                      srst,
  input  wire logic                      instr_valid,
  input  wire logic                      cond_present,
  input  cvd_pkg::cvd_cond_t             cond_code,
  input  wire logic                      loop_end_check,
  input  wire logic                      alu_zero,
  input  wire logic                      alu_neg,
  input  wire logic                      alu_carry,
  input  wire logic                      alu_ovf,
  input  wire logic                      mul_ovf,
  input  wire logic                      mul_sign,
  input  wire logic                      shf_ovf,
  input  wire logic                      shf_zero,
  input  wire logic                      bit_test_flag,
  input  wire logic                      loop_count_expired,
  input  wire logic [3:0]                flag_pin,
  input  wire logic                      br_valid,
  input  wire logic                      br_relative,
  input  wire logic [ADDR_W-1:0]         br_abs_addr,
  input  wire logic [OFFS_W-1:0]         br_offset,
  input  wire logic [ADDR_W-1:0]         br_pc,
  input  wire logic                      loop_abort_option,
  input  wire logic                      delayed_branch_option,
  input  wire logic                      mf_valid,
  input  wire logic                      mf_fixed,
  input  wire logic                      mf_to_mrf,
  input  wire logic [1:0]                mf_mx_sel,
  input  wire logic [1:0]                mf_my_sel,
  input  wire logic [1:0]                mf_ax_sel,
  input  wire logic [1:0]                mf_ay_sel,
  input  wire logic                      shf_imm_valid,
  input  wire logic                      shf_field_op,
  input  wire logic [11:0]               shf_imm,
  input  wire logic                      px_wr_low,
  input  wire logic                      px_wr_high,
  input  wire logic                      px_wr_comb,
  input  wire logic [`CVD_PX_W-1:0]      px_wdata,
  input  wire logic                      dm_access,
  input  wire logic [`CVD_DM_ADDR_W-1:0] dm_addr,
  input  wire logic                      pm_access,
  input  wire logic [ADDR_W-1:0]         pm_addr,
  input  wire logic                      stack_ovf,
  input  wire logic                      timer_zero,
  input  wire logic                      timer_high_prio,
  input  wire logic [3:0]                irq_pin_n,
  input  wire logic                      cb7_ovf,
  input  wire logic                      cb15_ovf,
  input  wire logic                      fix_ovf,
  input  wire logic                      flt_ovf,
  input  wire logic                      flt_unf,
  input  wire logic                      flt_inv,
  input  wire logic [31:0]               vector_mask,
  output logic                           exec_enable,
  output logic                           loop_terminate,
  output logic                           branch_taken,
  output logic [ADDR_W-1:0]              branch_target,
  output logic                           pop_loop_stacks,
  output logic                           pop_pc_stack,
  output logic                           branch_delayed,
  output logic [3:0]                     mul_x_reg,
  output logic [3:0]                     mul_y_reg,
  output logic [3:0]                     alu_x_reg,
  output logic [3:0]                     alu_y_reg,
  output logic                           signed_fractional_format,
  output logic                           signed_fractional_rounded_format,
  output logic [`CVD_FIELD_W-1:0]        shf_bit_pos,
  output logic [`CVD_FIELD_W-1:0]        shf_length,
  output logic [`CVD_SHAMT_W-1:0]        shf_amount,
  output logic [`CVD_PX_LOW_W-1:0]       bus_exchange_low,
  output logic [`CVD_PX_HIGH_W-1:0]      bus_exchange_high,
  output logic [`CVD_PX_W-1:0]           bus_exchange_combined,
  output logic [`CVD_DM_ADDR_W-1:0]      last_data_address_copy,
  output logic [ADDR_W-1:0]              last_program_address_copy,
  output logic                           vector_valid,
  output logic [`CVD_VEC_W-1:0]          vector_addr
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  generate
    if (ADDR_W < `CVD_VEC_W || OFFS_W < 2 || OFFS_W > ADDR_W)
    begin : g_bad_width
      $error("cvd_decoder: address or offset width unusable");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [3:0]                flag_meta;
    logic [3:0]                flag_sync;
    logic [3:0]                irq_meta;
    logic [3:0]                irq_sync_n;
    logic                      reset_pending;
    logic                      exec_enable;
    logic                      loop_terminate;
    logic                      branch_taken;
    logic [ADDR_W-1:0]         branch_target;
    logic                      pop_loop_stacks;
    logic                      pop_pc_stack;
    logic                      branch_delayed;
    logic [3:0]                mul_x_reg;
    logic [3:0]                mul_y_reg;
    logic [3:0]                alu_x_reg;
    logic [3:0]                alu_y_reg;
    logic                      sfrac;
    logic                      sfrac_rnd;
    logic [`CVD_FIELD_W-1:0]   bit_pos;
    logic [`CVD_FIELD_W-1:0]   length;
    logic [`CVD_SHAMT_W-1:0]   amount;
    logic [`CVD_PX_LOW_W-1:0]  px_low;
    logic [`CVD_PX_HIGH_W-1:0] px_high;
    logic [`CVD_DM_ADDR_W-1:0] dm_copy;
    logic [ADDR_W-1:0]         pm_copy;
    logic                      vec_valid;
    logic [`CVD_VEC_W-1:0]     vec_addr;
  } cvd_state_t;

  cvd_state_t st;
  cvd_state_t next_st;
  logic       cond_ok;
  logic [31:0] vec_req;

  function automatic logic [ADDR_W-1:0] cvd_sext(input logic [OFFS_W-1:0] v);
    cvd_sext = {{(ADDR_W-OFFS_W){v[OFFS_W-1]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // condition evaluation

  // flags come from pins, so only the synchronised copy is tested
  cvd_cond_eval u_cond
  (
    .code               (cond_code),
    .alu_zero           (alu_zero),
    .alu_neg            (alu_neg),
    .alu_carry          (alu_carry),
    .alu_ovf            (alu_ovf),
    .mul_ovf            (mul_ovf),
    .mul_sign           (mul_sign),
    .shf_ovf            (shf_ovf),
    .shf_zero           (shf_zero),
    .flag_in            (st.flag_sync),
    .bit_test_flag      (bit_test_flag),
    .loop_count_expired (loop_count_expired),
    .result             (cond_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // vector requests, index is slot number

  always_comb
  begin
    vec_req = 32'h0000_0000;
    // RULE_12 stack fault
    vec_req[`CVD_SLOT_STACK]   = stack_ovf;
    // RULE_13 timer priority choice
    vec_req[`CVD_SLOT_TMR_HI]  = timer_zero & timer_high_prio;
    vec_req[`CVD_SLOT_TMR_LO]  = timer_zero & !timer_high_prio;
    // RULE_16 irq slots
    for (int i = 0; i < 4; i++)
    begin
      vec_req[`CVD_SLOT_IRQ3 + 5'(i)] = !st.irq_sync_n[3-i];
    end
    // RULE_14 circular buffers
    vec_req[`CVD_SLOT_CB7]     = cb7_ovf;
    vec_req[`CVD_SLOT_CB15]    = cb15_ovf;
    // RULE_16 arithmetic exceptions
    vec_req[`CVD_SLOT_FIX_OVF] = fix_ovf;
    vec_req[`CVD_SLOT_FLT_OVF] = flt_ovf;
    vec_req[`CVD_SLOT_FLT_UNF] = flt_unf;
    vec_req[`CVD_SLOT_FLT_INV] = flt_inv;
    vec_req = vec_req & vector_mask;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_st = st;
    next_st.flag_meta  = flag_pin;
    next_st.flag_sync  = st.flag_meta;
    next_st.irq_meta   = irq_pin_n;
    next_st.irq_sync_n = st.irq_meta;
    next_st.reset_pending = 1'b0;

    // RULE_01 suppress on false
    next_st.exec_enable    = instr_valid & (!cond_present | cond_ok);
    // RULE_03 loop end test
    next_st.loop_terminate = loop_end_check & cond_ok;

    next_st.branch_taken = br_valid & (!cond_present | cond_ok);
    // RULE_06 absolute or relative
    next_st.branch_target = br_relative ? ADDR_W'(br_pc + cvd_sext(br_offset)) : br_abs_addr;
    // RULE_05 abort and delay
    next_st.pop_loop_stacks = next_st.branch_taken & loop_abort_option;
    next_st.pop_pc_stack    = next_st.branch_taken & loop_abort_option;
    next_st.branch_delayed  = next_st.branch_taken & delayed_branch_option;

    // RULE_07 operand quadrants
    next_st.mul_x_reg = {2'h0, mf_mx_sel};
    next_st.mul_y_reg = {2'h1, mf_my_sel};
    next_st.alu_x_reg = {2'h2, mf_ax_sel};
    next_st.alu_y_reg = {2'h3, mf_ay_sel};
    // RULE_08 rounding by destination
    next_st.sfrac     = mf_valid & mf_fixed;
    next_st.sfrac_rnd = mf_valid & mf_fixed & !mf_to_mrf;

    // RULE_09 immediate fields
    if (shf_imm_valid)
    begin
      next_st.bit_pos = shf_field_op ? shf_imm[5:0] : 6'h00;
      next_st.length  = shf_field_op ? shf_imm[11:6] : 6'h00;
      next_st.amount  = shf_field_op ? 8'h00 : shf_imm[7:0];
    end

    // RULE_10 halves and whole
    if (px_wr_comb)
    begin
      next_st.px_low  = px_wdata[`CVD_PX_LOW_W-1:0];
      next_st.px_high = px_wdata[`CVD_PX_W-1:`CVD_PX_LOW_W];
    end
    else
    begin
      if (px_wr_low)
        next_st.px_low  = px_wdata[`CVD_PX_LOW_W-1:0];
      if (px_wr_high)
        next_st.px_high = px_wdata[`CVD_PX_HIGH_W-1:0];
    end

    // RULE_11 only accesses update the copies; there is no write path
    if (dm_access)
      next_st.dm_copy = dm_addr;
    if (pm_access)
      next_st.pm_copy = pm_addr;

    // lowest slot wins, matching the fixed priority of the vector table
    next_st.vec_valid = |vec_req;
    next_st.vec_addr  = 8'h00;
    for (int s = 31; s >= 0; s--)
    begin
      if (vec_req[s])
        next_st.vec_addr = 8'(s << `CVD_SLOT_STEP);
    end
    // RULE_15 reset vector unmasked
    if (st.reset_pending)
    begin
      next_st.vec_valid = 1'b1;
      next_st.vec_addr  = `CVD_RESET_VECTOR;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st               <= '0;
      st.irq_meta      <= 4'hF;
      st.irq_sync_n    <= 4'hF;
      st.reset_pending <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign exec_enable                      = st.exec_enable;
  assign loop_terminate                   = st.loop_terminate;
  assign branch_taken                     = st.branch_taken;
  assign branch_target                    = st.branch_target;
  assign pop_loop_stacks                  = st.pop_loop_stacks;
  assign pop_pc_stack                     = st.pop_pc_stack;
  assign branch_delayed                   = st.branch_delayed;
  assign mul_x_reg                        = st.mul_x_reg;
  assign mul_y_reg                        = st.mul_y_reg;
  assign alu_x_reg                        = st.alu_x_reg;
  assign alu_y_reg                        = st.alu_y_reg;
  assign signed_fractional_format         = st.sfrac;
  assign signed_fractional_rounded_format = st.sfrac_rnd;
  assign shf_bit_pos                      = st.bit_pos;
  assign shf_length                       = st.length;
  assign shf_amount                       = st.amount;
  assign bus_exchange_low                 = st.px_low;
  assign bus_exchange_high                = st.px_high;
  assign bus_exchange_combined            = {st.px_high, st.px_low};
  assign last_data_address_copy           = st.dm_copy;
  assign last_program_address_copy        = st.pm_copy;
  assign vector_valid                     = st.vec_valid;
  assign vector_addr                      = st.vec_addr;

endmodule // cvd_decoder

//--- tb/cvd_decoder_sva.sv
// concurrent checker for the condition and vector decode block
`timescale 1ns/10ps

module cvd_decoder_sva
(
  input wire logic          mclk,
  input wire logic          srst,
  input wire logic          instr_valid,
  input wire logic          cond_present,
  input cvd_pkg::cvd_cond_t cond_code,
  input wire logic          loop_end_check,
  input wire logic          alu_zero,
  input wire logic          alu_neg,
  input wire logic          loop_count_expired,
  input wire logic          br_valid,
  input wire logic          loop_abort_option,
  input wire logic          stack_ovf,
  input wire logic [31:0]   vector_mask,
  input wire logic          px_wr_comb,
  input wire logic [47:0]   px_wdata,
  input wire logic          exec_enable,
  input wire logic          loop_terminate,
  input wire logic          branch_taken,
  input wire logic          pop_loop_stacks,
  input wire logic          pop_pc_stack,
  input wire logic          branch_delayed,
  input wire logic [47:0]   bus_exchange_combined,
  input wire logic          vector_valid,
  input wire logic [7:0]    vector_addr
);
  // flag codes go through a synchroniser, so only same-cycle codes are modelled here
  logic known;
  logic ev;
  assign known = cond_code inside {cvd_pkg::CVD_EQ, cvd_pkg::CVD_LT, cvd_pkg::CVD_LCE,
                                   cvd_pkg::CVD_FOREVER, cvd_pkg::CVD_TRUE};
  assign ev = (cond_code == cvd_pkg::CVD_EQ && alu_zero) || (cond_code == cvd_pkg::CVD_LT && alu_neg)
           || (cond_code == cvd_pkg::CVD_LCE && loop_count_expired) || cond_code == cvd_pkg::CVD_TRUE;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////
  AST_COND_EXEC: assert property (
    instr_valid && cond_present && known |=> exec_enable == $past(ev))
    else $error("exec enable wrong");
  AST_LOOP_TERM: assert property (
    loop_end_check && known |=> loop_terminate == $past(ev))
    else $error("loop terminate wrong");
  AST_BR_SUPPRESS: assert property (
    br_valid && cond_present && known && !ev |=> !branch_taken)
    else $error("branch on false condition");
  AST_POP_ABORT: assert property (
    branch_taken |-> pop_loop_stacks == $past(loop_abort_option) && pop_pc_stack == pop_loop_stacks)
    else $error("stack pops wrong");
  AST_NO_POP: assert property (
    !branch_taken |-> !pop_loop_stacks && !pop_pc_stack && !branch_delayed)
    else $error("pop or delay without branch");
  AST_PX_COMB: assert property (
    px_wr_comb |=> bus_exchange_combined == $past(px_wdata))
    else $error("combined exchange write lost");
  AST_STACK_VEC: assert property (
    stack_ovf && vector_mask[3] && !$past(srst) |=> vector_valid && vector_addr == 8'h18)
    else $error("stack fault vector wrong");
  AST_RESET_VEC: assert property (
    $fell(srst) |=> vector_valid && vector_addr == 8'h08)
    else $error("reset vector missing");

  COV_ABORT: cover property (branch_taken && pop_loop_stacks);
  COV_RESET: cover property ($fell(srst) ##1 vector_valid);
  COV_STACK: cover property (vector_valid && vector_addr == 8'h18);
endmodule // cvd_decoder_sva

////////////////////////////////////////
bind cvd_decoder cvd_decoder_sva chk_inst (.*);

//--- tb/cvd_decoder_bench.sv
// self-checking bench for the condition and vector decode block
`timescale 1ns/10ps

module cvd_decoder_bench;
  logic mclk, srst, instr_valid, cond_present, loop_end_check, alu_zero, alu_neg, alu_carry;
  logic alu_ovf, mul_ovf, mul_sign, shf_ovf, shf_zero, bit_test_flag, loop_count_expired;
  logic br_valid, br_relative, loop_abort_option, delayed_branch_option, mf_valid, mf_fixed;
  logic mf_to_mrf, shf_imm_valid, shf_field_op, px_wr_low, px_wr_high, px_wr_comb, dm_access;
  logic pm_access, stack_ovf, timer_zero, timer_high_prio, cb7_ovf, cb15_ovf, fix_ovf, flt_ovf;
  logic flt_unf, flt_inv, exec_enable, loop_terminate, branch_taken, pop_loop_stacks, ev;
  logic pop_pc_stack, branch_delayed, signed_fractional_format, signed_fractional_rounded_format;
  logic vector_valid;
  logic [1:0] mf_mx_sel, mf_my_sel, mf_ax_sel, mf_ay_sel;
  logic [3:0] flag_pin, irq_pin_n, mul_x_reg, mul_y_reg, alu_x_reg, alu_y_reg;
  logic [5:0] br_offset, shf_bit_pos, shf_length;
  logic [7:0] shf_amount, vector_addr;
  logic [10:0] st;
  logic [11:0] shf_imm;
  logic [15:0] bus_exchange_low;
  logic [23:0] br_abs_addr, br_pc, pm_addr, branch_target, last_program_address_copy;
  logic [31:0] dm_addr, vector_mask, bus_exchange_high, last_data_address_copy;
  logic [47:0] px_wdata, bus_exchange_combined;
  cvd_pkg::cvd_cond_t cond_code;
  int n_errors;
  int checks_done;
  int codes [10] = '{0, 1, 2, 3, 4, 5, 28, 29, 30, 31};
  logic [7:0] vexp [9] = '{8'h18, 8'h20, 8'h70, 8'h58, 8'h60, 8'h78, 8'h80, 8'h88, 8'h90};

  cvd_decoder cvd_decoder_inst (.*);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////
  // inputs move 1 ns after the edge, well clear of sampling
  task automatic cyc();
    @(posedge mclk);
    #1;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic vec_req(input logic [8:0] r);
    {flt_inv, flt_unf, flt_ovf, fix_ovf, cb15_ovf, cb7_ovf} = r[8:3];
    timer_zero = r[1] | r[2];
    timer_high_prio = r[1];
    stack_ovf = r[0];
  endtask

  function automatic logic exp_cond(input int c, input logic z, input logic n, input logic e);
    return c == 0 ? z : c == 1 ? !z : c == 2 ? !n : c == 3 ? n : c == 4 ? n | z
      : c == 5 ? !(n | z) : c == 28 ? e : c == 29 ? !e : c == 31;
  endfunction

  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // run is under two hundred cycles; this leaves ample margin
  initial
  begin
    repeat (3000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end

  ////////////////////////////////////////
  initial
  begin
    {instr_valid, cond_present, loop_end_check, alu_zero, alu_neg, alu_carry, alu_ovf, mul_ovf,
     mul_sign, shf_ovf, shf_zero, bit_test_flag, loop_count_expired, br_valid, br_relative,
     loop_abort_option, delayed_branch_option, mf_valid, mf_fixed, mf_to_mrf, shf_imm_valid,
     shf_field_op, px_wr_low, px_wr_high, px_wr_comb, dm_access, pm_access} = '0;
    {mf_mx_sel, mf_my_sel, mf_ax_sel, mf_ay_sel, flag_pin, br_offset, shf_imm, br_pc} = '0;
    {dm_addr, pm_addr, px_wdata, vector_mask} = '0;
    vec_req(9'h000);
    cond_code = cvd_pkg::CVD_EQ;
    br_abs_addr = 24'h00ABCD;
    irq_pin_n = 4'hF;
    n_errors = 0;
    checks_done = 0;
    srst = 1'b1;
    repeat (20) cyc();
    srst = 1'b0;
    stack_ovf = 1'b1;
    cyc();
    chk(vector_addr, 8'h08);
    chk(vector_valid, 1'b1);
    stack_ovf = 1'b0;
    cyc();
    chk(vector_valid, 1'b0);
    {instr_valid, cond_present, loop_end_check, br_valid} = 4'hF;
    for (int c = 0; c < 10; c++)
      for (int k = 0; k < 6; k++)
      begin
        cond_code = cvd_pkg::cvd_cond_t'(codes[c]);
        alu_zero = (k % 3 == 1);
        alu_neg = (k % 3 == 2);
        loop_count_expired = (k > 2);
        loop_abort_option = c[0];
        delayed_branch_option = k[0];
        cyc();
        ev = exp_cond(codes[c], alu_zero, alu_neg, loop_count_expired);
        chk(exec_enable, ev);
        chk(loop_terminate, ev);
        chk(branch_taken, ev);
        chk({pop_loop_stacks, pop_pc_stack}, {2{ev & c[0]}});
        chk(branch_delayed, ev & k[0]);
        if (ev)
          chk(branch_target, 24'h00ABCD);
      end
    cond_present = 1'b0;
    cond_code = cvd_pkg::CVD_FOREVER;
    cyc();
    chk(exec_enable, 1'b1);
    cond_present = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      st = p ? 11'h55A : 11'h2A5;
      {bit_test_flag, flag_pin, shf_zero, shf_ovf, mul_sign, mul_ovf, alu_ovf, alu_carry} = st;
      repeat (3) cyc();
      for (int c = 6; c < 28; c++)
      begin
        cond_code = cvd_pkg::cvd_cond_t'(c);
        cyc();
        chk(exec_enable, st[(c - 6) / 2] ^ c[0]);
      end
    end
    cond_code = cvd_pkg::CVD_TRUE;
    br_relative = 1'b1;
    br_pc = 24'h000100;
    br_offset = 6'h3E;
    cyc();
    chk(branch_target, 24'h0000FE);
    br_pc = 24'hFFFFF0;
    br_offset = 6'h1F;
    cyc();
    chk(branch_target, 24'h00000F);
    {br_valid, mf_valid, mf_fixed} = 3'h3;
    for (int i = 0; i < 4; i++)
    begin
      {mf_mx_sel, mf_my_sel, mf_ax_sel, mf_ay_sel} = {i[1:0], ~i[1:0], i[1:0] ^ 2'h1, 2'h3};
      mf_to_mrf = i[0];
      cyc();
      chk({mul_x_reg, mul_y_reg}, {2'h0, mf_mx_sel, 2'h1, mf_my_sel});
      chk({alu_x_reg, alu_y_reg}, {2'h2, mf_ax_sel, 4'hF});
      chk({signed_fractional_format, signed_fractional_rounded_format}, {1'b1, !i[0]});
    end
    {mf_valid, shf_imm_valid, shf_field_op, shf_imm} = {3'h3, 12'hFC3};
    cyc();
    chk({shf_bit_pos, shf_length, shf_amount}, {6'h03, 6'h3F, 8'h00});
    {shf_field_op, shf_imm} = {1'b0, 12'h0A7};
    cyc();
    chk({shf_bit_pos, shf_length, shf_amount}, {12'h000, 8'hA7});
    {shf_imm_valid, shf_imm, px_wr_low, px_wdata} = {13'h05C1, 1'b1, 48'h00000000BEEF};
    cyc();
    chk({shf_amount, bus_exchange_low}, {8'hA7, 16'hBEEF});
    {px_wr_low, px_wr_high, px_wdata} = {2'h1, 48'h0000CAFEF00D};
    cyc();
    chk(bus_exchange_combined, 48'hCAFEF00DBEEF);
    {px_wr_low, px_wr_comb, px_wdata} = {2'h3, 48'h123456789ABC};
    cyc();
    chk({bus_exchange_high, bus_exchange_low}, 48'h123456789ABC);
    {px_wr_low, px_wr_high, px_wr_comb, dm_access, pm_access} = 5'h03;
    {dm_addr, pm_addr} = {32'h89ABCDEF, 24'h123456};
    cyc();
    {dm_access, pm_access, dm_addr, pm_addr} = '0;
    cyc();
    chk(last_data_address_copy, 32'h89ABCDEF);
    chk(last_program_address_copy, 24'h123456);
    vector_mask = 32'hFFFFFFFF;
    for (int r = 0; r < 9; r++)
    begin
      vec_req(9'h001 << r);
      cyc();
      chk({vector_valid, vector_addr}, {1'b1, vexp[r]});
    end
    vec_req(9'h1FF);
    cyc();
    chk(vector_addr, 8'h18);
    vector_mask = 32'hFFFFFFF7;
    cyc();
    chk(vector_addr, 8'h20);
    vec_req(9'h000);
    irq_pin_n = 4'h6;
    repeat (3) cyc();
    chk({vector_valid, vector_addr}, {1'b1, 8'h28});
    irq_pin_n = 4'hE;
    repeat (3) cyc();
    chk(vector_addr, 8'h40);
    {irq_pin_n, vector_mask} = {4'hF, 32'h0};
    vec_req(9'h001);
    repeat (3) cyc();
    chk(vector_valid, 1'b0);
    srst = 1'b1;
    repeat (2) cyc();
    chk({exec_enable, last_data_address_copy}, 33'h0);
    srst = 1'b0;
    cyc();
    chk({vector_valid, vector_addr}, {1'b1, 8'h08});
    wrap_up();
  end
endmodule // cvd_decoder_bench
